//--- shared/status_ctrl_consts.svh
// Register offsets, field positions and timing figures for the status block.
// Included by the package users; holds defines only.
`ifndef STATUS_CTRL_CONSTS_SVH
`define STATUS_CTRL_CONSTS_SVH

`define CLK_MHZ          100
`define MS_TICK_US       1000
`define WDOG_PULSE_CYC   6'h20
`define STRAP_SETTLE     2'h2
`define NUM_MPINS        8

`define A_PIN_CFG        16'h0200
`define A_IRQ_MODE       16'h0208
`define A_MASK           16'h0209
`define A_WDOG_LO        16'h0211
`define A_WDOG_HI        16'h0212
`define A_RESET_FN       16'h0A03
`define A_CLEAR          16'h0A04
`define A_STATUS         16'h0D02
`define BANK_BYTES       16'h0008

`define DIR_BIT          7
`define RF_WDOG          0
`define RF_IRQ           1
`define RF_TWH           2
`define WDOG_IRQ_BIT     6'h00

`define IRQ_OD_LO        2'h0
`define IRQ_OS_HI        2'h1
`define IRQ_PP_HI        2'h2
`define IRQ_PP_LO        2'h3

`define FN_IO_UPDATE     7'h01
`define FN_POWER_DOWN    7'h02
`define FN_WDOG_RESET    7'h03
`define FN_IRQ_RESET     7'h04
`define FN_TWH_RESET     7'h05
`define FN_HOLDOVER      7'h10
`define FN_FREE_RUN      7'h11
`define FN_IPO_RESET     7'h12
`define FN_IPO_INC       7'h13
`define FN_IPO_DEC       7'h14
`define FN_REF_OVR       7'h20
`define FN_FORCE_VTO     7'h30
`define FN_EN_OUT_A      7'h40
`define FN_EN_OUT_B      7'h41
`define FN_EN_OUT_AB     7'h44
`define FN_DIST_SYNC     7'h45

`define MON_VALID        128'h00000000_0001000F_000F000F_07FF09F0

`endif

//--- shared/status_ctrl_pkg.sv
// Types shared by the status, control, interrupt and watchdog block.
// Numeric constants live in status_ctrl_consts.svh.
package status_ctrl_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

    typedef struct packed {
        logic       io_update;
        logic       power_down;
        logic       twh_reset;
        logic       holdover;
        logic       free_run;
        logic       ipo_reset;
        logic       ipo_inc;
        logic       ipo_dec;
        logic [3:0] ref_override;
        logic [3:0] force_vto;
        logic [1:0] out_enable;
        logic       dist_sync;
    } ctrl_t;

    typedef enum {
        FI_IO_UPDATE, FI_POWER_DOWN, FI_WDOG_RESET, FI_IRQ_RESET, FI_TWH_RESET,
        FI_HOLDOVER, FI_FREE_RUN, FI_IPO_RESET, FI_IPO_INC, FI_IPO_DEC,
        FI_OVR_A, FI_OVR_AA, FI_OVR_B, FI_OVR_BB,
        FI_VTO_A, FI_VTO_AA, FI_VTO_B, FI_VTO_BB,
        FI_EN_A, FI_EN_B, FI_EN_AB, FI_DIST_SYNC, FI_COUNT
    } fn_idx_t;

endpackage

//--- design/mpin_sync.sv
// Two-stage synchroniser for the multifunction pin inputs.
// Assumes pins are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module mpin_sync #(
    parameter int W = 8
) (
    input  wire logic         ref_clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            stage1  <= '0;
            level_o <= '0;
        end else begin
            stage1  <= pin_i;
            level_o <= stage1;
        end
    end
endmodule

//--- design/status_control_irq_watchdog.sv
// Multifunction pins, interrupt pin logic and watchdog timer.
// Assumes a byte-wide register port from the serial control port.
// Function
// - Output code 80 drives distribution sync pulse
// - Direction bit low makes pin an input
// - Reset: all pins inputs, function unused
// - Input codes 1-5 drive basic strobes; 2 is a level
// - Input codes 16-20 drive loop controls
// - Codes 32-35 override, 48-51 force timeouts
// - Codes 64,65,68 enable outputs; 69 syncs
// - Lowest pin index wins shared function
// - Straps sampled only after reset
// - Two-bit mode picks interrupt pin drive
// - Status bit sets on masked-in event
// - Clearing mask leaves status bit set
// - Interrupt asserted while any status set
// - Write-one clears status, clear self-resets
// - Clear-all bit or pin clears every status bit
// - 16-bit period in ms, zero disables
// - Watchdog runs continuously, raises interrupt
// - Timeout pin pulse lasts 32 clocks
// - Restart bit or pin restarts count
// - Direction bit high makes monitor output
// - Output codes 0-3: low, high, div32, watchdog
`timescale 1ns/1ps
`include "status_ctrl_consts.svh"
module status_control_irq_watchdog #(
    parameter int unsigned MS_CYCLES = `MS_TICK_US * `CLK_MHZ
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      srst_i,
    input  wire status_ctrl_pkg::reg_req_t reg_req_i,
    output logic [7:0]                     reg_rdata_o,
    input  wire logic [63:0]               irq_event_i,
    input  wire logic [127:0]              mon_src_i,
    input  wire logic [7:0]                mpin_i,
    output logic [7:0]                     mpin_o,
    output logic [7:0]                     mpin_oe_n_o,
    output logic                           irq_pin_o,
    output logic                           irq_oe_n_o,
    output status_ctrl_pkg::ctrl_t         ctrl_o,
    output logic [7:0]                     strap_o,
    output logic                           strap_valid_o
);
    import status_ctrl_pkg::*;

    localparam int NFN = int'(FI_COUNT);
    localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);
    localparam logic [6:0] FN_CODES [NFN] = '{
        `FN_IO_UPDATE, `FN_POWER_DOWN, `FN_WDOG_RESET, `FN_IRQ_RESET,
        `FN_TWH_RESET, `FN_HOLDOVER, `FN_FREE_RUN, `FN_IPO_RESET,
        `FN_IPO_INC, `FN_IPO_DEC,
        `FN_REF_OVR, 7'(`FN_REF_OVR + 7'h01), 7'(`FN_REF_OVR + 7'h02),
        7'(`FN_REF_OVR + 7'h03),
        `FN_FORCE_VTO, 7'(`FN_FORCE_VTO + 7'h01), 7'(`FN_FORCE_VTO + 7'h02),
        7'(`FN_FORCE_VTO + 7'h03),
        `FN_EN_OUT_A, `FN_EN_OUT_B, `FN_EN_OUT_AB, `FN_DIST_SYNC
    };

    // Lowest pin index overrides: it is visited last
    function automatic logic pin_drive(input logic [7:0][7:0] c,
                                       input logic [7:0]      l,
                                       input logic [6:0]      code);
        logic hit;
        hit = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (!c[i][`DIR_BIT] && c[i][6:0] == code) begin
                hit = l[i];
            end
        end
        return hit;
    endfunction

    logic [7:0][7:0] cfg;
    logic [7:0]      irq_mode_reg;
    logic [63:0]     mask;
    logic [63:0]     status;
    logic [15:0]     wdog_period;
    logic [16:0]     tick_cnt;
    logic [15:0]     ms_cnt;
    logic [5:0]      pulse_cnt;
    logic [4:0]      sys_div;
    logic [NFN-1:0]  fn_q;
    logic [1:0]      strap_wait;

    wire  [7:0]      pin_lvl;
    wire  [NFN-1:0]  fn;
    wire  [NFN-1:0]  fn_rise;
    wire  [7:0]      cfg_we;
    wire  [7:0]      mask_we;
    wire  [63:0]     clr_bits;

    // Pins arrive asynchronously
    mpin_sync #(
        .W (`NUM_MPINS)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .pin_i     (mpin_i),
        .level_o   (pin_lvl)
    );

    // Register decode
    wire        wr       = reg_req_i.wr;
    wire [15:0] addr     = reg_req_i.addr;
    wire [7:0]  wdata    = reg_req_i.wdata;
    wire [15:0] cfg_off  = addr - `A_PIN_CFG;
    wire [15:0] mask_off = addr - `A_MASK;
    wire [15:0] stat_off = addr - `A_STATUS;
    wire        in_cfg   = cfg_off < `BANK_BYTES;
    wire        in_mask  = mask_off < `BANK_BYTES;
    wire        in_stat  = stat_off < `BANK_BYTES;
    wire        wdog_wr  = wr && (addr == `A_WDOG_LO || addr == `A_WDOG_HI);
    wire        rf_wr    = wr && addr == `A_RESET_FN;
    wire [7:0]  rf_bits  = rf_wr ? wdata : 8'h00;

    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_bank
            assign cfg_we[k]  = wr && addr == 16'(`A_PIN_CFG + k);
            assign mask_we[k] = wr && addr == 16'(`A_MASK + k);
            assign clr_bits[8*k +: 8] =
                (wr && addr == 16'(`A_CLEAR + k)) ? wdata : 8'h00;

            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    cfg[k] <= 8'h00;
                end else if (cfg_we[k]) begin
                    cfg[k] <= wdata;
                end
            end

            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    mask[8*k +: 8] <= 8'h00;
                end else if (mask_we[k]) begin
                    mask[8*k +: 8] <= wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_mode_reg <= 8'h00;
            wdog_period  <= 16'h0000;
        end else if (wr && addr == `A_IRQ_MODE) begin
            irq_mode_reg <= wdata;
        end else if (wr && addr == `A_WDOG_LO) begin
            wdog_period[7:0] <= wdata;
        end else if (wr && addr == `A_WDOG_HI) begin
            wdog_period[15:8] <= wdata;
        end
    end

    // Clear and reset-function bytes are never stored, so they read zero
    wire [7:0] rd_mux =
        in_cfg  ? cfg[cfg_off[2:0]] :
        in_mask ? mask[{mask_off[2:0], 3'b000} +: 8] :
        in_stat ? status[{stat_off[2:0], 3'b000} +: 8] :
        (addr == `A_IRQ_MODE) ? irq_mode_reg :
        (addr == `A_WDOG_LO)  ? wdog_period[7:0] :
        (addr == `A_WDOG_HI)  ? wdog_period[15:8] : 8'h00;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= reg_req_i.rd ? rd_mux : 8'h00;
        end
    end

    // Pin input functions
    genvar f;
    generate
        for (f = 0; f < NFN; f++) begin : g_fn
            assign fn[f] = pin_drive(cfg, pin_lvl, FN_CODES[f]);
        end
    endgenerate

    // A config write can fake an edge; accepted as harmless
    assign fn_rise = fn & ~fn_q;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fn_q <= '0;
        end else begin
            fn_q <= fn;
        end
    end

    wire wdog_restart = rf_bits[`RF_WDOG] | fn_rise[FI_WDOG_RESET];
    wire clr_all      = rf_bits[`RF_IRQ] | fn_rise[FI_IRQ_RESET];

    ctrl_t next_ctrl;
    assign next_ctrl.io_update  = fn_rise[FI_IO_UPDATE];
    assign next_ctrl.power_down = fn[FI_POWER_DOWN];
    assign next_ctrl.twh_reset  = fn_rise[FI_TWH_RESET] | rf_bits[`RF_TWH];
    assign next_ctrl.holdover   = fn[FI_HOLDOVER];
    assign next_ctrl.free_run   = fn[FI_FREE_RUN];
    assign next_ctrl.ipo_reset  = fn_rise[FI_IPO_RESET];
    assign next_ctrl.ipo_inc    = fn_rise[FI_IPO_INC];
    assign next_ctrl.ipo_dec    = fn_rise[FI_IPO_DEC];
    assign next_ctrl.ref_override = fn[int'(FI_OVR_BB):int'(FI_OVR_A)];
    assign next_ctrl.force_vto  = fn_rise[int'(FI_VTO_BB):int'(FI_VTO_A)];
    assign next_ctrl.out_enable = {fn[FI_EN_B] | fn[FI_EN_AB],
                                   fn[FI_EN_A] | fn[FI_EN_AB]};
    assign next_ctrl.dist_sync  = fn_rise[FI_DIST_SYNC];

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl_o <= '0;
        end else begin
            ctrl_o <= next_ctrl;
        end
    end

    // Watchdog
    wire wdog_on   = |wdog_period;
    wire restart   = wdog_restart | wdog_wr;
    wire tick      = tick_cnt == MS_LAST;
    wire wdog_evt  = wdog_on && !restart && tick && (ms_cnt == wdog_period - 16'h0001);
    wire wdog_pulse = pulse_cnt != 6'h00;

    wire [16:0] next_tick_cnt = (!wdog_on || restart || tick) ? 17'h00000
                                                             : tick_cnt + 17'h00001;
    wire [15:0] next_ms_cnt   = (!wdog_on || restart || wdog_evt) ? 16'h0000 :
                                tick ? ms_cnt + 16'h0001 : ms_cnt;
    wire [5:0]  next_pulse    = wdog_evt ? `WDOG_PULSE_CYC :
                                wdog_pulse ? pulse_cnt - 6'h01 : 6'h00;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tick_cnt  <= 17'h00000;
            ms_cnt    <= 16'h0000;
            pulse_cnt <= 6'h00;
            sys_div   <= 5'h00;
        end else begin
            tick_cnt  <= next_tick_cnt;
            ms_cnt    <= next_ms_cnt;
            pulse_cnt <= next_pulse;
            sys_div   <= sys_div + 5'h01;
        end
    end

    // Interrupt status
    wire [63:0] ev       = irq_event_i | ({63'h0, wdog_evt} << `WDOG_IRQ_BIT);
    wire [63:0] ev_m     = ev & mask;
    wire [63:0] clr_vec  = clr_all ? {64{1'b1}} : clr_bits;
    // Set wins over a clear in the same cycle
    wire [63:0] next_status = (status & ~clr_vec) | ev_m;
    wire        irq_act  = |status;

    logic next_irq_pin;
    logic next_irq_oe_n;
    always_comb begin
        next_irq_oe_n = irq_mode_reg[1] ? 1'b0 : ~irq_act;
        case (irq_mode_reg[1:0])
            `IRQ_OD_LO: next_irq_pin = 1'b0;
            `IRQ_OS_HI: next_irq_pin = 1'b1;
            `IRQ_PP_HI: next_irq_pin = irq_act;
            `IRQ_PP_LO: next_irq_pin = ~irq_act;
            default:    next_irq_pin = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            status     <= 64'h0;
            irq_pin_o  <= 1'b0;
            irq_oe_n_o <= 1'b1;
        end else begin
            status     <= next_status;
            irq_pin_o  <= next_irq_pin;
            irq_oe_n_o <= next_irq_oe_n;
        end
    end

    // Monitor outputs
    wire [127:0] mon_vec = (mon_src_i & `MON_VALID) |
                           {124'h0, wdog_pulse, sys_div[4], 1'b1, 1'b0};

    genvar p;
    generate
        for (p = 0; p < 8; p++) begin : g_pin
            wire dir = cfg[p][`DIR_BIT];
            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    mpin_o[p]      <= 1'b0;
                    mpin_oe_n_o[p] <= 1'b1;
                end else begin
                    mpin_o[p]      <= dir & mon_vec[cfg[p][6:0]];
                    mpin_oe_n_o[p] <= ~dir;
                end
            end
        end
    endgenerate

    // Straps taken once the synchroniser has filled after reset
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            strap_wait    <= 2'h0;
            strap_o       <= 8'h00;
            strap_valid_o <= 1'b0;
        end else if (strap_wait != `STRAP_SETTLE) begin
            strap_wait <= strap_wait + 2'h1;
        end else if (!strap_valid_o) begin
            strap_o       <= pin_lvl;
            strap_valid_o <= 1'b1;
        end
    end

    // Checks
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    wire [7:0] dir_vec = {cfg[7][`DIR_BIT], cfg[6][`DIR_BIT], cfg[5][`DIR_BIT], cfg[4][`DIR_BIT],
                          cfg[3][`DIR_BIT], cfg[2][`DIR_BIT], cfg[1][`DIR_BIT], cfg[0][`DIR_BIT]};

    a_pin_direction: assert property (
        ##1 mpin_oe_n_o == ~$past(dir_vec))
        else $error("pin enable does not follow direction bit");

    a_mask_gates_set: assert property (
        ##1 ((status & ~$past(status)) & ~$past(mask)) == 64'h0)
        else $error("status bit set without mask");

    a_status_held: assert property (
        ##1 (($past(status) & ~status) & ~$past(clr_vec)) == 64'h0)
        else $error("status bit dropped without clear");

    a_clear_all_bits: assert property (
        clr_all |=> (status & ~$past(ev_m)) == 64'h0)
        else $error("clear-all left status bits");

    a_irq_push_pull: assert property (
        irq_mode_reg[1:0] == `IRQ_PP_HI |=> irq_pin_o == $past(irq_act) && !irq_oe_n_o)
        else $error("push-pull interrupt pin wrong");

    a_irq_open_drain: assert property (
        irq_mode_reg[1:0] == `IRQ_OD_LO |=> !irq_pin_o && irq_oe_n_o == !$past(irq_act))
        else $error("open-drain interrupt pin wrong");

    a_wdog_off_quiet: assert property (
        !wdog_on |=> tick_cnt == 17'h00000 && ms_cnt == 16'h0000)
        else $error("watchdog counted while disabled");

    a_wdog_pulse_len: assert property (
        $rose(wdog_pulse) |-> ##31 wdog_pulse ##1 !wdog_pulse)
        else $error("watchdog pulse not 32 clocks");

    a_wdog_restart: assert property (
        restart |=> tick_cnt == 17'h00000 && ms_cnt == 16'h0000)
        else $error("watchdog count not restarted");

    a_clear_reads_zero: assert property (
        reg_req_i.rd && addr == `A_CLEAR |=> reg_rdata_o == 8'h00)
        else $error("clear register read nonzero");
endmodule

//--- verif/board_model.sv
// Board side of the status block: pin drivers and line resistors.
// Assumes device enables are active low; the bench picks the pull.
`timescale 1ns/1ps
module board_model (
    input  wire logic       pull_up_i,
    input  wire logic [7:0] drive_i,
    input  wire logic [7:0] dev_pin_i,
    input  wire logic [7:0] dev_oe_n_i,
    input  wire logic       dev_irq_i,
    input  wire logic       dev_irq_oe_n_i,
    output logic      [7:0] mpin_level_o,
    output logic            irq_wire_o
);
    // Board drives only the pins that the device has released
    assign mpin_level_o = (dev_pin_i & ~dev_oe_n_i) | (drive_i & dev_oe_n_i);
    // Released line falls to the resistor, never to a stale level
    assign irq_wire_o = dev_irq_oe_n_i ? pull_up_i : dev_irq_i;
endmodule

//--- verif/status_control_irq_watchdog_tb.sv
// Self-checking bench for the status, interrupt and watchdog block.
// Assumes MS_CYCLES of 10, so one millisecond lasts ten clocks.
`timescale 1ns/1ps
`include "status_ctrl_consts.svh"
module status_control_irq_watchdog_tb;
    import status_ctrl_pkg::*;
    logic ref_clk_i, srst_i, irq_pin_o, irq_oe_n_o, strap_valid_o, pull_up, irq_wire;
    logic [7:0] rdata, mpin_o, mpin_oe_n_o, strap_o, drive, strap, mpin_level, m;
    logic [63:0] ev;
    logic [127:0] mon;
    reg_req_t req;
    ctrl_t ctrl_o, acc;
    int n_errors, comparisons, cycles, p, t, w, hi;

    status_control_irq_watchdog #(.MS_CYCLES(10)) u_status_control_irq_watchdog (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .irq_event_i(ev), .mon_src_i(mon), .mpin_i(mpin_level), .mpin_o(mpin_o),
        .mpin_oe_n_o(mpin_oe_n_o), .irq_pin_o(irq_pin_o), .irq_oe_n_o(irq_oe_n_o),
        .ctrl_o(ctrl_o), .strap_o(strap_o), .strap_valid_o(strap_valid_o));
    board_model u_board_model (
        .pull_up_i(pull_up), .drive_i(drive), .dev_pin_i(mpin_o), .dev_oe_n_i(mpin_oe_n_o),
        .dev_irq_i(irq_pin_o), .dev_irq_oe_n_i(irq_oe_n_o), .mpin_level_o(mpin_level),
        .irq_wire_o(irq_wire));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic report_and_stop();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the few thousand clocks the run needs
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge ref_clk_i);
        req.wr = 1'b0;
    endtask

    // Read data stands only in the cycle after the request edge
    task automatic rd_chk(input string nm, input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        @(negedge ref_clk_i);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge ref_clk_i);
        req.rd = 1'b0;
        d = rdata;
        chk_val(nm, 32'(e), 32'(d));
    endtask

    function automatic ctrl_t exp_ctrl(input int c);
        ctrl_t x;
        x = '0;
        case (c)
            1: x.io_update = 1'b1;
            2: x.power_down = 1'b1;
            5: x.twh_reset = 1'b1;
            16: x.holdover = 1'b1;
            17: x.free_run = 1'b1;
            18: x.ipo_reset = 1'b1;
            19: x.ipo_inc = 1'b1;
            20: x.ipo_dec = 1'b1;
            32, 33, 34, 35: x.ref_override[c - 32] = 1'b1;
            48, 49, 50, 51: x.force_vto[c - 48] = 1'b1;
            64: x.out_enable = 2'h1;
            65: x.out_enable = 2'h2;
            68: x.out_enable = 2'h3;
            69: x.dist_sync = 1'b1;
            default: x = '0;
        endcase
        return x;
    endfunction

    task automatic out_chk(input int q, input int c, input logic e);
        wr(16'(`A_PIN_CFG + q), 8'h80 | 8'(c));
        cyc(3);
        chk_val("pin out", 32'(e), 32'(mpin_o[q]));
        chk_val("pin oe_n", 0, 32'(mpin_oe_n_o[q]));
    endtask

    task automatic irq_chk(input logic act);
        for (int md = 0; md < 4; md++) begin
            wr(`A_IRQ_MODE, 8'(md));
            pull_up = (md == 0);
            cyc(2);
            chk_val("irq wire", 32'((md == 1 || md == 2) ? act : !act), 32'(irq_wire));
            chk_val("irq oe_n", 32'((md < 2) ? !act : 1'b0), 32'(irq_oe_n_o));
        end
    endtask

    task automatic wd_wait(output int tt, output int ww);
        tt = 0;
        ww = 0;
        while (mpin_o[6] !== 1'b1 && tt < 300) begin
            @(negedge ref_clk_i);
            tt++;
        end
        while (mpin_o[6] === 1'b1 && ww < 100) begin
            @(negedge ref_clk_i);
            ww++;
        end
    endtask

    initial begin
        void'($urandom(32'h67172E1B));
        req = '0;
        ev = '0;
        mon = '0;
        pull_up = 1'b1;
        drive = 8'($urandom);
        strap = drive;
        srst_i = 1'b1;
        cyc(4);
        srst_i = 1'b0;
        chk_val("oe_n", 32'hFF, 32'(mpin_oe_n_o));
        cyc(6);
        chk_val("strap", 32'(strap), 32'(strap_o));
        chk_val("strap valid", 1, 32'(strap_valid_o));
        drive = ~strap;
        cyc(5);
        chk_val("strap held", 32'(strap), 32'(strap_o));
        chk_val("ctrl idle", 0, 32'(ctrl_o));
        rd_chk("pin cfg", `A_PIN_CFG + 16'h0007, 8'h00);
        rd_chk("mode", `A_IRQ_MODE, 8'h00);
        drive = 8'h00;
        cyc(4);
        // Every input code once, on a random pin
        for (int c = 0; c < 128; c++) begin
            p = $urandom_range(7);
            wr(16'(`A_PIN_CFG + p), 8'(c));
            drive[p] = 1'b1;
            acc = '0;
            repeat (8) begin
                @(negedge ref_clk_i);
                acc = acc | ctrl_o;
            end
            chk_val("ctrl", 32'(exp_ctrl(c)), 32'(acc));
            drive[p] = 1'b0;
            cyc(6);
            wr(16'(`A_PIN_CFG + p), 8'h00);
        end
        wr(`A_PIN_CFG + 16'h0001, 8'h10);
        wr(`A_PIN_CFG + 16'h0003, 8'h10);
        drive[3] = 1'b1;
        cyc(6);
        chk_val("holdover", 0, 32'(ctrl_o.holdover));
        drive[1] = 1'b1;
        cyc(6);
        chk_val("holdover", 1, 32'(ctrl_o.holdover));
        drive = 8'h00;
        wr(`A_PIN_CFG + 16'h0003, 8'h00);
        // Monitor outputs
        p = $urandom_range(7);
        mon = {$urandom, $urandom, $urandom, $urandom};
        out_chk(p, 0, 1'b0);
        out_chk(p, 1, 1'b1);
        out_chk(p, 80, mon[80]);
        mon[80] = ~mon[80];
        out_chk(p, 80, mon[80]);
        out_chk(p, 81, 1'b0);
        wr(16'(`A_PIN_CFG + p), 8'h82);
        cyc(4);
        hi = 0;
        repeat (64) begin
            @(negedge ref_clk_i);
            hi += int'(mpin_o[p]);
        end
        chk_val("div32 high", 32, hi);
        wr(16'(`A_PIN_CFG + p), 8'h00);
        cyc(2);
        chk_val("pin input", 1, 32'(mpin_oe_n_o[p]));
        // Interrupt status, mask, clear
        wr(16'h0300, 8'hA5);
        rd_chk("unmapped", 16'h0300, 8'h00);
        m = 8'($urandom) | 8'h81;
        wr(`A_MASK, m);
        rd_chk("mask", `A_MASK, m);
        ev[15:0] = 16'hFFFF;
        cyc(1);
        ev = '0;
        rd_chk("status", `A_STATUS, m);
        rd_chk("status b1", `A_STATUS + 16'h0001, 8'h00);
        irq_chk(1'b1);
        wr(`A_MASK, 8'h00);
        rd_chk("status kept", `A_STATUS, m);
        wr(`A_CLEAR, 8'h01);
        rd_chk("status clr", `A_STATUS, m & 8'hFE);
        rd_chk("clear reg", `A_CLEAR, 8'h00);
        chk_val("irq still", 0, 32'(irq_wire));
        wr(`A_RESET_FN, 8'h02);
        rd_chk("status all", `A_STATUS, 8'h00);
        rd_chk("reset fn", `A_RESET_FN, 8'h00);
        irq_chk(1'b0);
        wr(`A_MASK, m);
        ev[7:0] = 8'hFF;
        cyc(1);
        ev = '0;
        wr(`A_PIN_CFG + 16'h0005, 8'h04);
        drive[5] = 1'b1;
        cyc(6);
        rd_chk("status pin", `A_STATUS, 8'h00);
        drive[5] = 1'b0;
        wr(`A_PIN_CFG + 16'h0005, 8'h00);
        // Watchdog: 5 ms is 50 clocks here
        wr(`A_IRQ_MODE, 8'h02);
        wr(`A_MASK, 8'h01);
        wr(`A_PIN_CFG + 16'h0006, 8'h83);
        wr(`A_PIN_CFG + 16'h0004, 8'h03);
        wr(`A_WDOG_HI, 8'h01);
        rd_chk("period hi", `A_WDOG_HI, 8'h01);
        wr(`A_WDOG_HI, 8'h00);
        wr(`A_WDOG_LO, 8'h05);
        wd_wait(t, w);
        chk_val("wd first", 1, 32'(t >= 47 && t <= 54));
        chk_val("wd pulse", 32, w);
        rd_chk("wd status", `A_STATUS, 8'h01);
        wd_wait(t, w);
        // Pulse start to pulse start: pulse, the two-cycle read, then the gap
        chk_val("wd period", 1, 32'(t + w + 2 >= 48 && t + w + 2 <= 52));
        for (int k = 0; k < 3; k++) begin
            cyc(10);
            case (k)
                0: wr(`A_RESET_FN, 8'h01);
                1: drive[4] = 1'b1;
                default: wr(`A_WDOG_LO, 8'h05);
            endcase
            wd_wait(t, w);
            drive[4] = 1'b0;
            chk_val("wd restart", 1, 32'(t >= 46 && t <= 57));
        end
        wr(`A_WDOG_LO, 8'h00);
        wr(`A_CLEAR, 8'h01);
        wd_wait(t, w);
        chk_val("wd off", 300, t);
        chk_val("irq off", 0, 32'(irq_pin_o));
        // Straps are taken again after a mid-run reset
        drive = 8'($urandom);
        srst_i = 1'b1;
        cyc(4);
        srst_i = 1'b0;
        chk_val("valid rst", 0, 32'(strap_valid_o));
        cyc(6);
        chk_val("strap rst", 32'(drive), 32'(strap_o));
        rd_chk("cfg rst", `A_PIN_CFG + 16'h0006, 8'h00);
        report_and_stop();
    end
endmodule
